// >>> cpu_alu_datapath.sv
// 16-bit execution datapath: alu, multiplier, divider, shifter, registers
`timescale 1ns/1ps
// Summary of operation
// RULE1: 23-bit program counter fetching 24-bit words with one-cycle prefetch.
// RULE2: single-cycle instructions except flow change, double moves, tables.
// RULE3: loop repeats next instruction with no overhead, interruptible anytime.
// RULE4: sixteen 16-bit working registers; last is the stack pointer.
// RULE5: memory read, register read, memory write and fetch in one cycle.
// RULE6: upper 32 Kbytes of data map to program page when enabled.
// RULE7: single-cycle 17x17 multiplier for signed, unsigned, mixed operands.
// RULE8: multiply modes 16x16 all signs, 16 by 5-bit literal, 8x8 unsigned.
// RULE9: divides run inside a repeat loop, 19 cycles, interruptible safely.
// RULE10: 32/16 and 16/16 divides; quotient and remainder to fixed registers.
// RULE11: one quotient bit per cycle; both divide sizes take equal time.
// RULE12: shifter does up to 16-position shifts in one cycle.
// RULE13: signed amount: positive right, negative left, zero unchanged.
// RULE14: 8 or 16-bit two's complement; carries act as borrows on subtract.
// RULE15: status bit 8 half carry from bit 4 (byte) or bit 8 (word).
// RULE16: status bits 7-5 priority level, joined with msb into 4 bits.
// RULE17: priority level bits read-only while nesting disable is set.
// RULE18: status bit 4 loop flag is read-only, high during a repeat loop.
// RULE19: status bit 3 set on negative result, cleared otherwise.
// RULE20: status bit 2 set on signed overflow, cleared otherwise.
// RULE21: core control bit 3 priority msb; software may only clear it.
// RULE22: core control bit 2 enables program window; unused bits read 0.
// RULE23: status bit 1 set on zero result, sticky for multi-precision.
// RULE24: status bit 0 set on carry out of result msb.
module cpu_alu_datapath
   import cpu_dp_pkg::*;
#(
   parameter logic [PC_W-1:0] RESET_PC = 23'h00_0000
) (
   input wire logic CORE_CLK_I,
   input wire logic RST_B_I,
   input wire axi_req_type AXI_REQ_I,
   output axi_rsp_type AXI_RSP_O,
   input wire logic FETCH_STALL_I,
   input wire logic [INSN_W-1:0] FETCH_DATA_I,
   output logic [PC_W-1:0] FETCH_ADDR_O,
   input wire logic INSN_VALID_I,
   input wire insn_type INSN_I,
   input wire logic LOOP_START_I,
   input wire logic [13:0] LOOP_COUNT_I,
   input wire logic IRQ_BREAK_I,
   input wire logic NESTING_DISABLE_I,
   input wire logic [DATA_W-1:0] MEM_RDATA_I,
   input wire logic [DATA_W-1:0] DATA_ADDR_I,
   output logic [DATA_W-1:0] MEM_WDATA_O,
   output logic MEM_WE_O,
   output logic WINDOW_HIT_O,
   output logic [PROG_ADDR_W-1:0] WINDOW_ADDR_O,
   output logic [INSN_W-1:0] INSN_WORD_O,
   output logic DIV_BUSY_O
);
   typedef struct packed {
      logic [PC_W-1:0] pc;
      logic [INSN_W-1:0] prefetch;
      logic [NUM_WREG-1:0][DATA_W-1:0] wreg;
      logic [15:0] status;
      logic [15:0] core_ctrl;
      logic [PAGE_W-1:0] win_page;
      logic [13:0] loop_cnt;
      logic loop_on;
      div_state_type dv_st;
      logic [4:0] dv_cnt;
      logic [31:0] dv_rem;
      logic [15:0] dv_quo;
      logic [15:0] dv_den;
      logic dv_neg_q;
      logic dv_neg_r;
      logic [15:0] mem_wdata;
      logic mem_we;
      logic aw_got;
      logic w_got;
      logic [7:0] aw_addr;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } state_type;

   state_type s_r;
   state_type s_nxt;

   function automatic logic reg_hit(input logic [7:0] a);
      reg_hit = (a == ADDR_STATUS) || (a == ADDR_CORE_CTRL) ||
         (a == ADDR_WIN_PAGE) || (a[7:6] == ADDR_WREG_BASE[7:6] &&
         a[1:0] == 2'b00);
   endfunction

   // one signed 17x17 array serves every mode via operand extension
   function automatic logic [31:0] mul17(input logic [16:0] a,
                                         input logic [16:0] b);
      logic signed [33:0] p;
      p = $signed(a) * $signed(b);
      mul17 = p[31:0];
   endfunction

   logic [15:0] opa;
   logic [15:0] opb;
   logic [16:0] sum;
   logic [16:0] ext_a;
   logic [16:0] ext_b;
   logic [31:0] product;
   logic [15:0] shifted;
   logic [4:0] shamt;
   logic [15:0] res;
   logic res_msb;
   logic [17:0] trial;

   always_comb begin
      s_nxt = s_r;
      s_nxt.mem_we = 1'b0;
      opa = s_r.wreg[INSN_I.src_a];
      opb = INSN_I.lit_b ? INSN_I.literal :
            (INSN_I.use_mem ? MEM_RDATA_I : s_r.wreg[INSN_I.src_b]); // RULE5
      ext_a = 17'h0_0000;
      ext_b = 17'h0_0000;
      sum = 17'h0_0000;
      shifted = opa;
      shamt = 5'h00;
      res = 16'h0000;
      trial = 18'h0_0000;
      // RULE7 RULE8
      case (INSN_I.mul_mode)
         MUL_SS: begin
            ext_a = {opa[15], opa};
            ext_b = {opb[15], opb};
         end
         MUL_SU: begin
            ext_a = {opa[15], opa};
            ext_b = {1'b0, opb};
         end
         MUL_US: begin
            ext_a = {1'b0, opa};
            ext_b = {opb[15], opb};
         end
         MUL_SU5: begin
            ext_a = {opa[15], opa};
            ext_b = {12'h000, opb[4:0]};
         end
         MUL_UU5: begin
            ext_a = {1'b0, opa};
            ext_b = {12'h000, opb[4:0]};
         end
         MUL_BB: begin
            ext_a = {9'h000, opa[7:0]};
            ext_b = {9'h000, opb[7:0]};
         end
         default: begin
            ext_a = {1'b0, opa};
            ext_b = {1'b0, opb};
         end
      endcase
      product = mul17(ext_a, ext_b);
      // RULE12 RULE13
      if (!opb[15] && opb != 16'h0000) begin
         shamt = (opb[15:5] != 11'h000) ? 5'h10 : opb[4:0];
         shifted = INSN_I.signed_op ? 16'($signed(opa) >>> shamt) :
                   16'(opa >> shamt);
      end else if (opb[15]) begin
         shamt = (opb < 16'hfff0) ? 5'h10 : 5'(16'h0000 - opb);
         shifted = 16'(opa << shamt);
      end
      res_msb = INSN_I.byte_mode ? res[7] : res[15];
      // RULE1 RULE2: prefetch holds next word while the current one runs
      if (!FETCH_STALL_I && s_r.dv_st != DV_RUN) begin
         s_nxt.prefetch = FETCH_DATA_I;
         s_nxt.pc = PC_W'(s_r.pc + 23'h00_0002);
      end
      // RULE3 RULE18: loop flag follows the repeat counter
      if (LOOP_START_I) begin
         s_nxt.loop_cnt = LOOP_COUNT_I;
         s_nxt.loop_on = 1'b1;
      end else if (s_r.loop_on && INSN_VALID_I && !IRQ_BREAK_I) begin
         if (s_r.loop_cnt == 14'h0000) s_nxt.loop_on = 1'b0;
         else s_nxt.loop_cnt = 14'(s_r.loop_cnt - 14'h0001);
      end
      s_nxt.status[ST_LOOP] = s_nxt.loop_on; // RULE18
      if (INSN_VALID_I && s_r.dv_st == DV_IDLE) begin
         case (INSN_I.op)
            OP_ADD, OP_SUB: begin
               // RULE14: subtract is add of complement with carry as borrow
               sum = {1'b0, opa} + {1'b0, (INSN_I.op == OP_SUB) ? ~opb :
                     opb} + {16'h0000, INSN_I.carry_in_use ?
                     s_r.status[ST_CARRY] : (INSN_I.op == OP_SUB)};
               res = sum[15:0];
            end
            OP_AND: res = opa & opb;
            OP_IOR: res = opa | opb;
            OP_XOR: res = opa ^ opb;
            OP_MUL: res = product[15:0];
            OP_SHIFT: res = shifted;
            OP_MOV: res = opb;
            default: res = opa;
         endcase
         res_msb = INSN_I.byte_mode ? res[7] : res[15];
         if (INSN_I.op != OP_DIV && INSN_I.op != OP_NOP) begin
            if (INSN_I.mem_dst) begin
               s_nxt.mem_wdata = res;
               s_nxt.mem_we = 1'b1;
            end else if (INSN_I.byte_mode) begin
               s_nxt.wreg[INSN_I.dst][7:0] = res[7:0];
            end else begin
               s_nxt.wreg[INSN_I.dst] = res;
            end
            if (INSN_I.op == OP_MUL && !INSN_I.byte_mode)
               s_nxt.wreg[4'(INSN_I.dst + 4'h1)] = product[31:16];
            s_nxt.status[ST_NEG] = res_msb; // RULE19
            // RULE23: extended ops only ever clear the zero flag
            if (INSN_I.byte_mode ? res[7:0] == 8'h00 : res == 16'h0000)
               s_nxt.status[ST_ZERO] = INSN_I.keep_zero ?
                  s_r.status[ST_ZERO] : 1'b1;
            else s_nxt.status[ST_ZERO] = 1'b0;
            if (INSN_I.op == OP_ADD || INSN_I.op == OP_SUB) begin
               s_nxt.status[ST_HALF_CARRY] = INSN_I.byte_mode ? // RULE15
                  (opa[4] ^ ((INSN_I.op == OP_SUB) ? ~opb[4] : opb[4]) ^
                   res[4]) :
                  (opa[8] ^ ((INSN_I.op == OP_SUB) ? ~opb[8] : opb[8]) ^
                   res[8]);
               s_nxt.status[ST_CARRY] = INSN_I.byte_mode ? // RULE24
                  (opa[8] ^ ((INSN_I.op == OP_SUB) ? ~opb[8] : opb[8]) ^
                   res[8]) : sum[16];
               s_nxt.status[ST_WRAP] = INSN_I.byte_mode ? // RULE20
                  ((opa[7] == ((INSN_I.op == OP_SUB) ? ~opb[7] : opb[7]))
                   && res[7] != opa[7]) :
                  ((opa[15] == ((INSN_I.op == OP_SUB) ? ~opb[15] : opb[15]))
                   && res[15] != opa[15]);
            end
         end else if (INSN_I.op == OP_DIV && s_r.loop_on) begin // RULE9
            // RULE10: magnitudes are divided, signs fixed at the end
            s_nxt.dv_st = DV_RUN;
            s_nxt.dv_cnt = 5'h00;
            s_nxt.dv_den = (INSN_I.signed_op && opb[15]) ?
               16'(16'h0000 - opb) : opb;
            s_nxt.dv_quo = 16'h0000;
            if (INSN_I.long_div) begin
               s_nxt.dv_rem = {s_r.wreg[{INSN_I.src_a[3:1], 1'b1}],
                               s_r.wreg[{INSN_I.src_a[3:1], 1'b0}]};
            end else begin
               s_nxt.dv_rem = INSN_I.signed_op ? {{16{opa[15]}}, opa} :
                              {16'h0000, opa};
            end
            s_nxt.dv_neg_r = INSN_I.signed_op && s_nxt.dv_rem[31];
            s_nxt.dv_neg_q = INSN_I.signed_op && (s_nxt.dv_rem[31] ^ opb[15]);
            if (s_nxt.dv_neg_r) s_nxt.dv_rem = 32'(32'h0000_0000 - s_nxt.dv_rem);
         end
      end
      // RULE9 RULE11: fixed step count, state held across an interrupt break
      if (s_r.dv_st == DV_RUN && !IRQ_BREAK_I) begin
         s_nxt.dv_cnt = 5'(s_r.dv_cnt + 5'h01);
         if (s_r.dv_cnt < 5'h10) begin
            // 17-bit partial remainder so no top bit is lost on a big divisor
            trial = {1'b0, s_r.dv_rem[31:15]} - {2'b00, s_r.dv_den};
            if (!trial[17]) begin
               s_nxt.dv_rem = {trial[15:0], s_r.dv_rem[14:0], 1'b1};
            end else begin
               s_nxt.dv_rem = {s_r.dv_rem[30:0], 1'b0};
            end
            s_nxt.dv_quo = s_nxt.dv_rem[15:0];
         end
         if (s_r.dv_cnt == DIV_LAST) begin
            s_nxt.dv_st = DV_IDLE;
            s_nxt.wreg[0] = s_r.dv_neg_q ? 16'(16'h0000 - s_r.dv_quo) :
                            s_r.dv_quo; // RULE10
            s_nxt.wreg[1] = s_r.dv_neg_r ?
               16'(16'h0000 - s_r.dv_rem[31:16]) :
               s_r.dv_rem[31:16];
         end
      end
      // axi write channels, accepted in either order
      if (AXI_REQ_I.awvalid && !s_r.aw_got && !s_r.bvalid) begin
         s_nxt.aw_got = 1'b1;
         s_nxt.aw_addr = AXI_REQ_I.awaddr[7:0];
      end
      if (AXI_REQ_I.wvalid && !s_r.w_got && !s_r.bvalid) begin
         s_nxt.w_got = 1'b1;
         s_nxt.w_data = AXI_REQ_I.wdata;
         s_nxt.w_strb = AXI_REQ_I.wstrb;
      end
      if (s_r.aw_got && s_r.w_got) begin
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = reg_hit(s_r.aw_addr) ? RESP_OKAY : RESP_SLVERR;
         if (s_r.aw_addr == ADDR_STATUS && s_r.w_strb[0]) begin
            // RULE17 RULE18: loop flag and locked priority stay as they were
            s_nxt.status[7:0] = (s_r.w_data[7:0] & STATUS_WMASK[7:0] &
               {NESTING_DISABLE_I ? 3'b000 : 3'b111, 5'h1f}) |
               (s_nxt.status[7:0] & ~(STATUS_WMASK[7:0] &
               {NESTING_DISABLE_I ? 3'b000 : 3'b111, 5'h1f}));
         end
         if (s_r.aw_addr == ADDR_STATUS && s_r.w_strb[1])
            s_nxt.status[ST_HALF_CARRY] = s_r.w_data[ST_HALF_CARRY];
         if (s_r.aw_addr == ADDR_CORE_CTRL && s_r.w_strb[0]) begin
            s_nxt.core_ctrl[CC_WIN_EN] = s_r.w_data[CC_WIN_EN]; // RULE22
            if (!s_r.w_data[CC_PRIO_MSB])
               s_nxt.core_ctrl[CC_PRIO_MSB] = 1'b0; // RULE21
         end
         if (s_r.aw_addr == ADDR_WIN_PAGE && s_r.w_strb[0])
            s_nxt.win_page = s_r.w_data[7:0];
         if (s_r.aw_addr[7:6] == ADDR_WREG_BASE[7:6] &&
             s_r.aw_addr[1:0] == 2'b00) begin
            if (s_r.w_strb[0])
               s_nxt.wreg[s_r.aw_addr[5:2]][7:0] = s_r.w_data[7:0]; // RULE4
            if (s_r.w_strb[1])
               s_nxt.wreg[s_r.aw_addr[5:2]][15:8] = s_r.w_data[15:8];
         end
      end
      if (s_r.bvalid && AXI_REQ_I.bready) s_nxt.bvalid = 1'b0;
      if (AXI_REQ_I.arvalid && !s_r.rvalid) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = reg_hit(AXI_REQ_I.araddr[7:0]) ? RESP_OKAY :
                       RESP_SLVERR;
         s_nxt.rdata = 32'h0000_0000;
         if (AXI_REQ_I.araddr[7:0] == ADDR_STATUS)
            s_nxt.rdata = {16'h0000, s_r.status};
         else if (AXI_REQ_I.araddr[7:0] == ADDR_CORE_CTRL)
            s_nxt.rdata = {16'h0000, s_r.core_ctrl}; // RULE22
         else if (AXI_REQ_I.araddr[7:0] == ADDR_WIN_PAGE)
            s_nxt.rdata = {24'h00_0000, s_r.win_page};
         else if (reg_hit(AXI_REQ_I.araddr[7:0]))
            s_nxt.rdata = {16'h0000, s_r.wreg[AXI_REQ_I.araddr[5:2]]};
      end else if (s_r.rvalid && AXI_REQ_I.rready) begin
         s_nxt.rvalid = 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_B_I) begin
         s_r <= '0;
         s_r.pc <= RESET_PC;
         s_r.status <= STATUS_RST;
         s_r.core_ctrl <= CORE_CTRL_RST;
         s_r.win_page <= WIN_PAGE_RST;
         s_r.dv_st <= DV_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // RULE6: upper data half becomes a window into a program page
   assign WINDOW_HIT_O = s_r.core_ctrl[CC_WIN_EN] && DATA_ADDR_I[15];
   assign WINDOW_ADDR_O = {1'b0, s_r.win_page, DATA_ADDR_I[14:0]};
   assign FETCH_ADDR_O = s_r.pc;
   assign INSN_WORD_O = s_r.prefetch;
   assign MEM_WDATA_O = s_r.mem_wdata;
   assign MEM_WE_O = s_r.mem_we;
   assign DIV_BUSY_O = (s_r.dv_st == DV_RUN);
   assign AXI_RSP_O.awready = !s_r.aw_got && !s_r.bvalid;
   assign AXI_RSP_O.wready = !s_r.w_got && !s_r.bvalid;
   assign AXI_RSP_O.bvalid = s_r.bvalid;
   assign AXI_RSP_O.bresp = s_r.bresp;
   assign AXI_RSP_O.arready = !s_r.rvalid;
   assign AXI_RSP_O.rvalid = s_r.rvalid;
   assign AXI_RSP_O.rdata = s_r.rdata;
   assign AXI_RSP_O.rresp = s_r.rresp;

   property p_div_len;
      @(posedge CORE_CLK_I) disable iff (!RST_B_I)
      $rose(DIV_BUSY_O) |-> DIV_BUSY_O [*8];
   endproperty
   a_div_len: assert property (p_div_len) else $error("divide ended early"); // RULE9
   property p_div_bound;
      @(posedge CORE_CLK_I) disable iff (!RST_B_I)
      ($rose(DIV_BUSY_O) && !IRQ_BREAK_I) |-> ##[1:40] !DIV_BUSY_O;
   endproperty
   a_div_bound: assert property (p_div_bound) else $error("divide hung"); // RULE11
   property p_loop_flag;
      @(posedge CORE_CLK_I) disable iff (!RST_B_I)
      LOOP_START_I |=> s_r.status[ST_LOOP];
   endproperty
   a_loop_flag: assert property (p_loop_flag) else $error("loop flag low"); // RULE18
   property p_prio_lock;
      @(posedge CORE_CLK_I) disable iff (!RST_B_I)
      NESTING_DISABLE_I |=> $stable(s_r.status[7:5]);
   endproperty
   a_prio_lock: assert property (p_prio_lock) else $error("priority changed"); // RULE17
   property p_msb_clear_only;
      @(posedge CORE_CLK_I) disable iff (!RST_B_I)
      !s_r.core_ctrl[CC_PRIO_MSB] |=> !s_r.core_ctrl[CC_PRIO_MSB];
   endproperty
   a_msb_clear_only: assert property (p_msb_clear_only) else $error("msb set"); // RULE21
   property p_ctrl_unused;
      @(posedge CORE_CLK_I) disable iff (!RST_B_I)
      s_r.core_ctrl[15:4] == 12'h000 && s_r.core_ctrl[1:0] == 2'b00;
   endproperty
   a_ctrl_unused: assert property (p_ctrl_unused) else $error("unused bit set"); // RULE22
   property p_window;
      @(posedge CORE_CLK_I) disable iff (!RST_B_I)
      WINDOW_HIT_O |-> DATA_ADDR_I[15] && WINDOW_ADDR_O[22:15] == s_r.win_page;
   endproperty
   a_window: assert property (p_window) else $error("window address wrong"); // RULE6
   property p_pc_step;
      @(posedge CORE_CLK_I) disable iff (!RST_B_I)
      (!FETCH_STALL_I && !DIV_BUSY_O) |=> FETCH_ADDR_O ==
         PC_W'($past(FETCH_ADDR_O) + 23'h00_0002);
   endproperty
   a_pc_step: assert property (p_pc_step) else $error("pc did not advance"); // RULE1
   c_div: cover property (@(posedge CORE_CLK_I) $fell(DIV_BUSY_O));
   c_loop: cover property (@(posedge CORE_CLK_I) $fell(s_r.status[ST_LOOP]));
   c_window: cover property (@(posedge CORE_CLK_I) WINDOW_HIT_O);
endmodule

// >>> cpu_alu_datapath_16bit_tb.sv
// self-checking bench for the 16-bit execution datapath
`timescale 1ns/1ps
module cpu_alu_datapath_16bit_tb
   import cpu_dp_pkg::*;
;
   logic clk = 1'h0, rst_b = 1'h0, stall = 1'h0, ivalid = 1'h0, lstart = 1'h0;
   logic [INSN_W-1:0] fdata = 24'h00_0000;
   logic [13:0] lcount = 14'h0000;
   logic [15:0] mrdata = 16'h0000, daddr = 16'h0000;
   axi_req_type req = '0;
   axi_rsp_type rsp;
   insn_type insn = '0;
   logic [PC_W-1:0] faddr;
   logic [INSN_W-1:0] iword;
   logic [15:0] mwdata;
   logic mwe, whit, dbusy;
   logic [PROG_ADDR_W-1:0] waddr;
   logic nest = 1'h0;
   logic irq = 1'h0;
   logic [31:0] seed = 32'h7841_6e79;
   int miscompares = 0, samples_checked = 0, cyc = 0;
   cpu_alu_datapath cpu_alu_datapath_inst (.CORE_CLK_I(clk), .RST_B_I(rst_b),
      .AXI_REQ_I(req), .AXI_RSP_O(rsp), .FETCH_STALL_I(stall),
      .FETCH_DATA_I(fdata), .FETCH_ADDR_O(faddr), .INSN_VALID_I(ivalid),
      .INSN_I(insn), .LOOP_START_I(lstart), .LOOP_COUNT_I(lcount),
      .IRQ_BREAK_I(irq), .NESTING_DISABLE_I(nest), .MEM_RDATA_I(mrdata),
      .DATA_ADDR_I(daddr), .MEM_WDATA_O(mwdata), .MEM_WE_O(mwe),
      .WINDOW_HIT_O(whit), .WINDOW_ADDR_O(waddr), .INSN_WORD_O(iword),
      .DIV_BUSY_O(dbusy));
   always #2.5 clk = ~clk;
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // ceiling well above the few hundred cycles the sequence needs
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares = miscompares + 1;
         end_of_test();
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("unexpected %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // master holds each channel until its own handshake edge
   task automatic wr(input logic [7:0] a, input logic [15:0] d,
                     output logic [1:0] r);
      @(posedge clk);
      req.awaddr <= {24'h00_0000, a};
      req.wdata <= {16'h0000, d};
      req.wstrb <= 4'hf;
      req.awvalid <= 1'h1;
      req.wvalid <= 1'h1;
      req.bready <= 1'h1;
      forever begin
         @(posedge clk);
         if (req.awvalid && rsp.awready) req.awvalid <= 1'h0;
         if (req.wvalid && rsp.wready) req.wvalid <= 1'h0;
         if (rsp.bvalid) begin
            r = rsp.bresp;
            req.bready <= 1'h0;
            break;
         end
      end
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] d,
                     output logic [1:0] r);
      @(posedge clk);
      req.araddr <= {24'h00_0000, a};
      req.arvalid <= 1'h1;
      req.rready <= 1'h1;
      forever begin
         @(posedge clk);
         if (req.arvalid && rsp.arready) req.arvalid <= 1'h0;
         if (rsp.rvalid) begin
            d = rsp.rdata[15:0];
            r = rsp.rresp;
            req.rready <= 1'h0;
            break;
         end
      end
   endtask
   task automatic rchk(input string nm, input logic [7:0] a, logic [15:0] e);
      logic [15:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk(nm, {r, 14'h0000, d}, {RESP_OKAY, 14'h0000, e});
   endtask
   task automatic ex(input alu_op_type op, mul_mode_type m, logic [3:0] d);
      insn_type t;
      t = '0;
      t.op = op;
      t.mul_mode = m;
      t.dst = d;
      t.src_a = 4'h1;
      t.src_b = 4'h2;
      @(posedge clk);
      insn <= t;
      ivalid <= 1'h1;
      @(posedge clk);
      ivalid <= 1'h0;
   endtask
   function automatic logic [15:0] add_st(logic [15:0] a, b);
      logic [16:0] s;
      logic [8:0] h;
      s = {1'h0, a} + {1'h0, b};
      h = {1'h0, a[7:0]} + {1'h0, b[7:0]};
      return {7'h00, h[8], 4'h0, s[15], (a[15] == b[15]) && (s[15] != a[15]),
              s[15:0] == 16'h0000, s[16]};
   endfunction
   logic [15:0] a, b, v;
   logic [1:0] r;
   logic [31:0] p;
   logic [15:0] ca[6] = '{16'h7fff, 16'hffff, 16'h0000, 16'h0001, 16'hfffd,
                          16'h0010};
   int n;
   initial begin
      repeat (20) @(posedge clk);
      rst_b <= 1'h1;
      rchk("status", ADDR_STATUS, STATUS_RST);
      rchk("core_ctrl", ADDR_CORE_CTRL, CORE_CTRL_RST);
      rchk("wreg15", ADDR_WREG_BASE + 8'h3c, 16'h0000);
      rd(8'h3c, v, r);
      chk("rd_resp", r, RESP_SLVERR);
      wr(8'h3c, 16'hffff, r);
      chk("wr_resp", r, RESP_SLVERR);
      // prefetch steps the pc by one instruction and captures the word
      @(posedge clk);
      fdata <= 24'(rnd());
      @(posedge clk);
      #1 chk("iword", iword, fdata);
      p = faddr;
      @(posedge clk);
      stall <= 1'h1;
      #1 chk("pc_step", faddr, p + 2);
      @(posedge clk);
      @(posedge clk);
      #1 chk("pc_hold", faddr, p + 2);
      stall <= 1'h0;
      for (int i = 0; i < 10; i++) begin
         a = (i < 2) ? ca[i] : 16'(rnd());
         b = (i < 2) ? 16'h0001 : 16'(rnd());
         wr(ADDR_WREG_BASE + 8'h04, a, r);
         wr(ADDR_WREG_BASE + 8'h08, b, r);
         ex(OP_ADD, MUL_SS, 4'h3);
         rchk("add", ADDR_WREG_BASE + 8'h0c, a + b);
         rchk("flags", ADDR_STATUS, add_st(a, b));
         ex(i[0] ? OP_MUL : OP_SUB, i[1] ? MUL_SS : MUL_UU, 4'h4);
         if (i[1]) p = $signed(a) * $signed(b);
         else p = {16'h0000, a} * {16'h0000, b};
         if (!i[0]) p = {16'h0000, a - b};
         rchk("mul_lo", ADDR_WREG_BASE + 8'h10, p[15:0]);
         if (i[0]) rchk("mul_hi", ADDR_WREG_BASE + 8'h14, p[31:16]);
      end
      // shift amounts: zero, right, left and full-width right
      wr(ADDR_WREG_BASE + 8'h04, 16'hb3c5, r);
      for (int i = 2; i < 6; i++) begin
         wr(ADDR_WREG_BASE + 8'h08, ca[i], r);
         ex(OP_SHIFT, MUL_SS, 4'h3);
         n = $signed(ca[i]);
         v = (n >= 0) ? 16'hb3c5 >> n : 16'hb3c5 << (-n);
         rchk("shift", ADDR_WREG_BASE + 8'h0c, v);
      end
      // unsigned divide inside a repeat loop
      a = 16'(rnd());
      b = 16'(rnd()) | 16'h0001;
      wr(ADDR_WREG_BASE + 8'h04, a, r);
      wr(ADDR_WREG_BASE + 8'h08, b, r);
      @(posedge clk);
      // single pass, so the loop flag is low again for the status checks
      lcount <= 14'h0000;
      lstart <= 1'h1;
      @(posedge clk);
      lstart <= 1'h0;
      ex(OP_DIV, MUL_SS, 4'h0);
      // two break cycles mid-divide stretch it without losing state
      n = 0;
      @(posedge clk);
      while (dbusy === 1'h1 && n < 40) begin
         n++;
         irq <= (n == 3 || n == 4);
         @(posedge clk);
      end
      chk("div_cycles", n, DIV_CYCLES + 2);
      rchk("quot", ADDR_WREG_BASE, a / b);
      rchk("rem", ADDR_WREG_BASE + 8'h04, a % b);
      // window mapping of the upper data half
      wr(ADDR_CORE_CTRL, 16'hffff, r);
      rchk("core_ctrl", ADDR_CORE_CTRL, 16'h0004);
      wr(ADDR_WIN_PAGE, 16'h005a, r);
      daddr <= 16'h8123;
      @(posedge clk);
      chk("win_hit", whit, 1'h1);
      chk("win_addr", waddr, {1'h0, 8'h5a, 15'h0123});
      daddr <= 16'h0123;
      @(posedge clk);
      chk("win_miss", whit, 1'h0);
      // priority bits locked by nesting disable, loop flag never written
      nest <= 1'h1;
      wr(ADDR_STATUS, 16'hffff, r);
      rchk("st_lock", ADDR_STATUS, 16'h010f);
      nest <= 1'h0;
      wr(ADDR_STATUS, 16'hffff, r);
      rchk("st_open", ADDR_STATUS, 16'h01ef);
      end_of_test();
   end
endmodule

// >>> cpu_dp_pkg.sv
// shared constants, types and register map of the 16-bit execution datapath
package cpu_dp_pkg;
   localparam int DATA_W = 16;
   localparam int PC_W = 23;
   localparam int INSN_W = 24;
   localparam int NUM_WREG = 16;
   localparam int PAGE_W = 8;
   localparam int PROG_ADDR_W = 24;
   localparam int DIV_CYCLES = 19;
   localparam logic [4:0] DIV_LAST = 5'h12;
   // axi register byte addresses
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_CORE_CTRL = 8'h04;
   localparam logic [7:0] ADDR_WIN_PAGE = 8'h08;
   localparam logic [7:0] ADDR_WREG_BASE = 8'h40;
   // cpu_status field positions
   localparam int ST_HALF_CARRY = 8;
   localparam int ST_PRIO_LO = 5;
   localparam int ST_LOOP = 4;
   localparam int ST_NEG = 3;
   localparam int ST_WRAP = 2;
   localparam int ST_ZERO = 1;
   localparam int ST_CARRY = 0;
   // core_control field positions
   localparam int CC_PRIO_MSB = 3;
   localparam int CC_WIN_EN = 2;
   localparam logic [15:0] STATUS_RST = 16'h0000;
   localparam logic [15:0] CORE_CTRL_RST = 16'h0000;
   localparam logic [15:0] STATUS_WMASK = 16'h01ef;
   localparam logic [7:0] WIN_PAGE_RST = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [3:0] {
      OP_ADD = 4'h0, OP_SUB = 4'h1, OP_AND = 4'h2, OP_IOR = 4'h3,
      OP_XOR = 4'h4, OP_MUL = 4'h5, OP_SHIFT = 4'h6, OP_DIV = 4'h7,
      OP_MOV = 4'h8, OP_NOP = 4'hf
   } alu_op_type;

   typedef enum logic [2:0] {
      MUL_SS = 3'h0, MUL_UU = 3'h1, MUL_SU5 = 3'h2, MUL_UU5 = 3'h3,
      MUL_US = 3'h4, MUL_SU = 3'h5, MUL_BB = 3'h6
   } mul_mode_type;

   typedef enum logic [2:0] {
      DV_IDLE = 3'b001, DV_RUN = 3'b010, DV_DONE = 3'b100
   } div_state_type;

   typedef struct packed {
      alu_op_type op;
      mul_mode_type mul_mode;
      logic byte_mode;
      logic signed_op;
      logic long_div;
      logic use_mem;
      logic mem_dst;
      logic carry_in_use;
      logic keep_zero;
      logic [3:0] dst;
      logic [3:0] src_a;
      logic [3:0] src_b;
      logic [15:0] literal;
      logic lit_b;
   } insn_type;

   typedef struct packed {
      logic [31:0] awaddr;
      logic awvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic wvalid;
      logic bready;
      logic [31:0] araddr;
      logic arvalid;
      logic rready;
   } axi_req_type;

   typedef struct packed {
      logic awready;
      logic wready;
      logic [1:0] bresp;
      logic bvalid;
      logic arready;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic rvalid;
   } axi_rsp_type;
endpackage
